// file: logic/sff_status_regs.sv
// sff_status_regs: apb register bank and status flags of the serial fifo port
// assumes external fifos report occupancy on sys_clk and accept one push or pop per cycle
`timescale 1ns/100ps
module sff_status_regs #(
    parameter logic [4:0] DEPTH = sff_pkg::SFF_FIFO_DEPTH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clkEn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sff_pkg::SFF_ADDR_W-1:0] paddr,
    input wire logic [sff_pkg::SFF_DATA_W-1:0] pwdata,
    output logic [sff_pkg::SFF_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // fifo side
    input wire sff_pkg::sff_levels_s levels,
    output logic txPush,
    output logic [sff_pkg::SFF_DATA_W-1:0] txPushData,
    output logic rxPop,
    input wire logic [sff_pkg::SFF_DATA_W-1:0] rxPopData,
    // control data side
    output logic [sff_pkg::SFF_REG_W-1:0] txCtrlData,
    input wire logic txCtrlTaken,
    input wire logic rxCtrlLoad,
    input wire logic [sff_pkg::SFF_REG_W-1:0] rxCtrlIn,
    // enables and requests
    output logic txEnable,
    output logic rxEnable,
    output logic txIrqReq,
    output logic ctrlIrqReq
);
    import sff_pkg::*;

    sff_lvl_s lvl;
    sff_flags_s flags_q;
    sff_flags_s flags_d;
    sff_flags_s shown;

    logic respQ_q;
    logic respQ_d;
    logic slvErr_q;
    logic [SFF_DATA_W-1:0] prdata_q;
    logic txEn_q;
    logic rxEn_q;
    logic [2:0] txWm_q;
    logic [15:0] irqEn_q;
    logic [SFF_REG_W-1:0] txCtrl_q;
    logic [SFF_REG_W-1:0] rxCtrl_q;
    logic [SFF_DATA_W-1:0] txData_q;
    logic txPush_q;
    logic rxWasFull_q;

    sff_level_flags #(
        .DEPTH(DEPTH)
    ) u_level (
        .levels(levels),
        .txWatermark(txWm_q),
        .lvl(lvl)
    );

    // bus phases: one wait state so read data leaves a flop
    logic accessPhase;
    logic firstAccess;
    logic doneAccess;
    assign accessPhase = psel & penable & clkEn;
    assign firstAccess = accessPhase & ~respQ_q;
    assign doneAccess = accessPhase & respQ_q;

    // address decode
    logic hitPortCtrl;
    logic hitFifoCtrl;
    logic hitStatus;
    logic hitIrqEn;
    logic hitTxCtrl;
    logic hitRxCtrl;
    logic hitTxData;
    logic hitRxData;
    logic mapped;
    assign hitPortCtrl = (paddr == SFF_OFF_PORT_CTRL);
    assign hitFifoCtrl = (paddr == SFF_OFF_FIFO_CTRL);
    assign hitStatus = (paddr == SFF_OFF_STATUS);
    assign hitIrqEn = (paddr == SFF_OFF_IRQ_EN);
    assign hitTxCtrl = (paddr == SFF_OFF_TX_CTRL_DATA);
    assign hitRxCtrl = (paddr == SFF_OFF_RX_CTRL_DATA);
    assign hitTxData = (paddr == SFF_OFF_TX_DATA);
    assign hitRxData = (paddr == SFF_OFF_RX_DATA);
    assign mapped = hitPortCtrl | hitFifoCtrl | hitStatus | hitIrqEn | hitTxCtrl | hitRxCtrl | hitTxData | hitRxData;

    // strobes: writes act on the completing edge, read side effects on the capture edge
    logic wrEnable;
    logic wrPortCtrl;
    logic wrFifoCtrl;
    logic wrIrqEn;
    logic wrTxCtrl;
    logic wrTxData;
    logic rdEnable;
    logic rdRxCtrl;
    logic rdRxData;
    assign wrEnable = doneAccess & pwrite;
    assign wrPortCtrl = wrEnable & hitPortCtrl;
    assign wrFifoCtrl = wrEnable & hitFifoCtrl;
    assign wrIrqEn = wrEnable & hitIrqEn;
    assign wrTxCtrl = wrEnable & hitTxCtrl;
    assign wrTxData = wrEnable & hitTxData;
    assign rdEnable = firstAccess & ~pwrite;
    assign rdRxCtrl = rdEnable & hitRxCtrl;
    assign rdRxData = rdEnable & hitRxData;

    // prohibited watermark codes are refused and the old code is kept
    logic [2:0] wmIn;
    logic wmLegal;
    assign wmIn = pwdata[SFF_FC_TX_WM_LSB +: 3];
    assign wmLegal = (wmIn == SFF_WM_16) | wmIn[2];

    // flag next state; the ready and rx-full sets win over a same-cycle clear, a tx data write clears tx-empty
    logic rxFullRise;
    assign rxFullRise = lvl.rxFullNow & ~rxWasFull_q;
    assign flags_d.txCtrlReady = txCtrlTaken | (flags_q.txCtrlReady & ~wrTxCtrl);
    // a pending push keeps the flag clear until the fifo count catches up
    assign flags_d.txFifoEmpty = lvl.txEmptyNow & ~wrTxData & ~txPush_q;
    assign flags_d.txDataRequest = lvl.txReqNow;
    assign flags_d.rxCtrlReady = rxCtrlLoad | (flags_q.rxCtrlReady & ~rdRxCtrl);
    assign flags_d.rxFifoFull = rxFullRise | (flags_q.rxFifoFull & lvl.rxFullNow & ~rdRxData);

    // flags other than tx control ready count only while their direction is enabled
    assign shown.txCtrlReady = flags_q.txCtrlReady;
    assign shown.txFifoEmpty = flags_q.txFifoEmpty & txEn_q;
    assign shown.txDataRequest = flags_q.txDataRequest & txEn_q;
    assign shown.rxCtrlReady = flags_q.rxCtrlReady & rxEn_q;
    assign shown.rxFifoFull = flags_q.rxFifoFull & rxEn_q;

    // status word; unlisted bits, bit 11 among them, read as zero
    logic [15:0] statusWord;
    always_comb begin
        statusWord = SFF_RST_STATUS;
        statusWord[SFF_ST_TX_CTRL_READY] = shown.txCtrlReady;
        statusWord[SFF_ST_TX_FIFO_EMPTY] = shown.txFifoEmpty;
        statusWord[SFF_ST_TX_DATA_REQUEST] = shown.txDataRequest;
        statusWord[SFF_ST_RESERVED] = 1'b0;
        statusWord[SFF_ST_RX_CTRL_READY] = shown.rxCtrlReady;
        statusWord[SFF_ST_RX_FIFO_FULL] = shown.rxFifoFull;
    end

    logic [15:0] portCtrlWord;
    logic [15:0] fifoCtrlWord;
    always_comb begin
        portCtrlWord = 16'h0000;
        portCtrlWord[SFF_PC_TX_ENABLE] = txEn_q;
        portCtrlWord[SFF_PC_RX_ENABLE] = rxEn_q;
        fifoCtrlWord = 16'h0000;
        fifoCtrlWord[SFF_FC_TX_WM_LSB +: 3] = txWm_q;
        fifoCtrlWord[SFF_FC_TX_FREE_LSB +: SFF_LEVEL_W] = lvl.txFree;
        fifoCtrlWord[SFF_FC_RX_LEVEL_LSB +: SFF_LEVEL_W] = levels.rxLevel;
    end

    // read selection; write-only and unmapped locations read zero
    logic [SFF_DATA_W-1:0] readWord;
    assign readWord = ({SFF_DATA_W{hitPortCtrl}} & {16'h0000, portCtrlWord})
        | ({SFF_DATA_W{hitFifoCtrl}} & {16'h0000, fifoCtrlWord})
        | ({SFF_DATA_W{hitStatus}} & {16'h0000, statusWord})
        | ({SFF_DATA_W{hitIrqEn}} & {16'h0000, irqEn_q})
        | ({SFF_DATA_W{hitRxCtrl}} & {16'h0000, rxCtrl_q})
        | ({SFF_DATA_W{hitRxData}} & rxPopData);

    // access phase handshake state
    always_comb begin
        respQ_d = respQ_q;
        if (!psel) begin
            respQ_d = 1'b0;
        end else if (firstAccess) begin
            respQ_d = 1'b1;
        end else if (doneAccess) begin
            respQ_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            respQ_q <= 1'b0;
            slvErr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (clkEn) begin
            respQ_q <= respQ_d;
            if (firstAccess) begin
                slvErr_q <= ~mapped;
                prdata_q <= pwrite ? 32'h0000_0000 : readWord;
            end
        end
    end

    // software controls
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            txEn_q <= 1'b0;
            rxEn_q <= 1'b0;
            txWm_q <= SFF_RST_TX_WM;
            irqEn_q <= SFF_RST_IRQ_EN;
        end else if (clkEn) begin
            if (wrPortCtrl) begin
                txEn_q <= pwdata[SFF_PC_TX_ENABLE];
                rxEn_q <= pwdata[SFF_PC_RX_ENABLE];
            end
            if (wrFifoCtrl && wmLegal) begin
                txWm_q <= wmIn;
            end
            if (wrIrqEn) begin
                irqEn_q <= pwdata[15:0] & SFF_IRQ_EN_MASK;
            end
        end
    end

    // control data holding registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            txCtrl_q <= 16'h0000;
            rxCtrl_q <= 16'h0000;
        end else if (clkEn) begin
            // an unsent value is simply overwritten by the next write
            if (wrTxCtrl) begin
                txCtrl_q <= pwdata[SFF_REG_W-1:0];
            end
            if (rxCtrlLoad) begin
                rxCtrl_q <= rxCtrlIn;
            end
        end
    end

    // transmit push, registered so the fifo sees clean data
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            txPush_q <= 1'b0;
            txData_q <= 32'h0000_0000;
        end else if (clkEn) begin
            txPush_q <= wrTxData;
            if (wrTxData) begin
                txData_q <= pwdata;
            end
        end
    end

    // status flags
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flags_q <= '0;
            rxWasFull_q <= 1'b0;
        end else if (clkEn) begin
            flags_q <= flags_d;
            rxWasFull_q <= lvl.rxFullNow;
        end
    end

    // outputs
    assign prdata = prdata_q;
    assign pready = respQ_q & clkEn;
    assign pslverr = respQ_q & clkEn & slvErr_q;
    assign txPush = txPush_q & clkEn;
    assign txPushData = txData_q;
    assign rxPop = rdRxData;
    assign txCtrlData = txCtrl_q;
    assign txEnable = txEn_q;
    assign rxEnable = rxEn_q;
    assign txIrqReq = shown.txDataRequest & irqEn_q[SFF_ST_TX_DATA_REQUEST];
    assign ctrlIrqReq = (shown.txCtrlReady & irqEn_q[SFF_ST_TX_CTRL_READY])
        | (shown.txFifoEmpty & irqEn_q[SFF_ST_TX_FIFO_EMPTY])
        | (shown.rxCtrlReady & irqEn_q[SFF_ST_RX_CTRL_READY])
        | (shown.rxFifoFull & irqEn_q[SFF_ST_RX_FIFO_FULL]);

endmodule

// file: shared/sff_pkg.sv
// sff_pkg: constants, register map and carrier types for the serial fifo status flag block
// assumes a 32-bit apb slave on sys_clk and fifo occupancy counters supplied from outside
package sff_pkg;

    localparam int SFF_DATA_W = 32;
    localparam int SFF_ADDR_W = 8;
    localparam int SFF_LEVEL_W = 5;
    localparam int SFF_REG_W = 16;
    localparam logic [4:0] SFF_FIFO_DEPTH = 5'h10;

    // byte addresses
    localparam logic [7:0] SFF_OFF_PORT_CTRL = 8'h00;
    localparam logic [7:0] SFF_OFF_FIFO_CTRL = 8'h04;
    localparam logic [7:0] SFF_OFF_STATUS = 8'h08;
    localparam logic [7:0] SFF_OFF_IRQ_EN = 8'h0C;
    localparam logic [7:0] SFF_OFF_TX_CTRL_DATA = 8'h10;
    localparam logic [7:0] SFF_OFF_RX_CTRL_DATA = 8'h14;
    localparam logic [7:0] SFF_OFF_TX_DATA = 8'h18;
    localparam logic [7:0] SFF_OFF_RX_DATA = 8'h1C;

    // status and interrupt enable bit positions
    localparam int SFF_ST_TX_CTRL_READY = 14;
    localparam int SFF_ST_TX_FIFO_EMPTY = 13;
    localparam int SFF_ST_TX_DATA_REQUEST = 12;
    localparam int SFF_ST_RESERVED = 11;
    localparam int SFF_ST_RX_CTRL_READY = 10;
    localparam int SFF_ST_RX_FIFO_FULL = 9;

    // port control fields
    localparam int SFF_PC_TX_ENABLE = 9;
    localparam int SFF_PC_RX_ENABLE = 8;

    // fifo control fields
    localparam int SFF_FC_TX_WM_LSB = 13;
    localparam int SFF_FC_TX_FREE_LSB = 8;
    localparam int SFF_FC_RX_LEVEL_LSB = 0;

    // reset values and interrupt enable write mask
    localparam logic [15:0] SFF_RST_STATUS = 16'h0000;
    localparam logic [15:0] SFF_RST_IRQ_EN = 16'h0000;
    localparam logic [2:0] SFF_RST_TX_WM = 3'h0;
    localparam logic [15:0] SFF_IRQ_EN_MASK = 16'h7600;

    // watermark codes and thresholds in empty stages
    localparam logic [2:0] SFF_WM_16 = 3'h0;
    localparam logic [2:0] SFF_WM_12 = 3'h4;
    localparam logic [2:0] SFF_WM_8 = 3'h5;
    localparam logic [2:0] SFF_WM_4 = 3'h6;
    localparam logic [2:0] SFF_WM_1 = 3'h7;
    localparam logic [4:0] SFF_THR_16 = 5'h10;
    localparam logic [4:0] SFF_THR_12 = 5'h0C;
    localparam logic [4:0] SFF_THR_8 = 5'h08;
    localparam logic [4:0] SFF_THR_4 = 5'h04;
    localparam logic [4:0] SFF_THR_1 = 5'h01;

    typedef struct packed {
        logic [4:0] txLevel;
        logic [4:0] rxLevel;
    } sff_levels_s;

    typedef struct packed {
        logic txEmptyNow;
        logic txReqNow;
        logic rxFullNow;
        logic [4:0] txFree;
    } sff_lvl_s;

    typedef struct packed {
        logic txCtrlReady;
        logic txFifoEmpty;
        logic txDataRequest;
        logic rxCtrlReady;
        logic rxFifoFull;
    } sff_flags_s;

endpackage

// file: logic/sff_level_flags.sv
// sff_level_flags: level-derived terms of the status flags
// assumes occupancy counts that never exceed the fifo depth
`timescale 1ns/100ps
module sff_level_flags #(
    parameter logic [4:0] DEPTH = sff_pkg::SFF_FIFO_DEPTH
) (
    // occupancy and watermark
    input wire sff_pkg::sff_levels_s levels,
    input wire logic [2:0] txWatermark,
    // derived terms
    output sff_pkg::sff_lvl_s lvl
);
    import sff_pkg::*;

    logic [4:0] threshold;
    logic [4:0] txFree;

    // prohibited codes fall back to the full-depth threshold
    always_comb begin
        unique case (txWatermark)
            SFF_WM_12: threshold = SFF_THR_12;
            SFF_WM_8: threshold = SFF_THR_8;
            SFF_WM_4: threshold = SFF_THR_4;
            SFF_WM_1: threshold = SFF_THR_1;
            default: threshold = SFF_THR_16;
        endcase
    end

    assign txFree = DEPTH - levels.txLevel;
    assign lvl.txFree = txFree;
    assign lvl.txEmptyNow = (levels.txLevel == 5'h00);
    assign lvl.txReqNow = (txFree >= threshold);
    assign lvl.rxFullNow = (levels.rxLevel == DEPTH);

endmodule

// file: bench/sff_status_regs_sva.sv
// sff_status_regs_sva: port-level checks of the status flag block
// assumes it is bound to sff_status_regs and sees only its ports
`timescale 1ns/100ps
module sff_status_regs_sva #(
    parameter logic [4:0] DEPTH = 5'h10
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clkEn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // fifo side and requests
    input wire logic txPush,
    input wire logic [31:0] txPushData,
    input wire logic rxPop,
    input wire logic txEnable,
    input wire logic rxEnable,
    input wire logic txIrqReq,
    input wire logic ctrlIrqReq
);
    import sff_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire stRead = pready && !pwrite && paddr == SFF_OFF_STATUS;
    wire txWr = pready && pwrite && paddr == SFF_OFF_TX_DATA;
    sequence s_start;
        $rose(penable) && psel && clkEn;
    endsequence
    sequence s_tx_write;
        s_start ##0 (pwrite && paddr == SFF_OFF_TX_DATA) ##1 pready;
    endsequence
    a_one_wait_state: assert property (s_start ##1 clkEn |-> pready)
        else $error("ready late");
    a_pop_first_access: assert property (s_start ##0 (!pwrite && paddr == SFF_OFF_RX_DATA) |-> rxPop ##1 !rxPop)
        else $error("bad pop");
    a_push_after_write: assert property (s_tx_write |=> txPush && txPushData == $past(pwdata))
        else $error("no push");
    a_push_needs_write: assert property (txPush |-> $past(txWr))
        else $error("stray push");
    a_reserved_bit_zero: assert property (stRead |-> prdata[31:15] == 17'h0_0000 && !prdata[11])
        else $error("reserved bit set");
    a_rx_flags_gated: assert property (stRead && !rxEnable |-> prdata[10:9] == 2'h0)
        else $error("rx flag ungated");
    a_tx_flags_gated: assert property (stRead && !txEnable |-> prdata[13:12] == 2'h0)
        else $error("tx flag ungated");
    a_txirq_needs_enable: assert property (!txEnable |-> !txIrqReq)
        else $error("tx irq while disabled");
    a_reset_clears_outs: assert property ($fell(srst) |-> !(pready || txIrqReq || ctrlIrqReq || txEnable || rxEnable))
        else $error("outputs not reset");
    a_freeze_no_strobe: assert property (!clkEn |-> !pready && !txPush && !rxPop)
        else $error("strobe while frozen");
endmodule

bind sff_status_regs sff_status_regs_sva #(.DEPTH(DEPTH)) u_sva (.sys_clk(sys_clk), .srst(srst), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .txPush(txPush), .txPushData(txPushData), .rxPop(rxPop), .txEnable(txEnable),
    .rxEnable(rxEnable), .txIrqReq(txIrqReq), .ctrlIrqReq(ctrlIrqReq));

// file: bench/sff_fifo_model.sv
// sff_fifo_model: occupancy counters of the tx and rx fifos
// assumes one push or pop per cycle and a bench that never overfills
`timescale 1ns/100ps
module sff_fifo_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // dut side
    input wire logic txPush,
    input wire logic rxPop,
    output sff_pkg::sff_levels_s levels,
    output logic [31:0] rxPopData,
    // bench commands
    input wire logic txFlush,
    input wire logic rxFill
);
    import sff_pkg::*;
    logic [4:0] txLvl_q;
    logic [4:0] rxLvl_q;
    logic [15:0] pops_q;
    assign levels = '{txLevel: txLvl_q, rxLevel: rxLvl_q};
    // an empty fifo shows a changing pattern, never a stale head
    assign rxPopData = (rxLvl_q != 5'h00) ? {16'h5a00, pops_q} : {16'ha5ff, ~pops_q};
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            txLvl_q <= 5'h00;
            rxLvl_q <= 5'h00;
            pops_q <= 16'h0000;
        end else begin
            txLvl_q <= txFlush ? 5'h00 : txLvl_q + {4'h0, txPush};
            rxLvl_q <= rxLvl_q + {4'h0, rxFill} - {4'h0, rxPop};
            pops_q <= pops_q + {15'h0000, rxPop};
        end
    end
endmodule

// file: bench/test_serial_fifo_status_flags.sv
// test_serial_fifo_status_flags: random and corner tests of the status flag bank
// assumes the fifo model for occupancy; the bench drives the control pulses
`timescale 1ns/100ps
module test_serial_fifo_status_flags;
    import sff_pkg::*;
    logic sys_clk, srst, clkEn, psel, penable, pwrite, pready, pslverr, txPush, rxPop, e;
    logic txCtrlTaken, rxCtrlLoad, txEnable, rxEnable, txIrqReq, ctrlIrqReq, txFlush, rxFill;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, txPushData, rxPopData, r;
    logic [15:0] txCtrlData, rxCtrlIn, v;
    logic [2:0] code;
    sff_levels_s levels;
    int miscompares, samples_checked, k, thr;
    sff_status_regs dut (.sys_clk(sys_clk), .srst(srst), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .levels(levels), .txPush(txPush), .txPushData(txPushData), .rxPop(rxPop), .rxPopData(rxPopData),
        .txCtrlData(txCtrlData), .txCtrlTaken(txCtrlTaken), .rxCtrlLoad(rxCtrlLoad), .rxCtrlIn(rxCtrlIn),
        .txEnable(txEnable), .rxEnable(rxEnable), .txIrqReq(txIrqReq), .ctrlIrqReq(ctrlIrqReq));
    sff_fifo_model fifo (.sys_clk(sys_clk), .srst(srst), .txPush(txPush), .rxPop(rxPop), .levels(levels),
        .rxPopData(rxPopData), .txFlush(txFlush), .rxFill(rxFill));
    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    function automatic int thrOf(input logic [2:0] c);
        return (c == 3'h4) ? 12 : (c == 3'h5) ? 8 : (c == 3'h6) ? 4 : (c == 3'h7) ? 1 : 16;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // master holds the request until ready is sampled high at a rising edge, then releases it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'h1 && n < 40);
        if (n >= 40) begin
            miscompares++;
            end_of_test();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0000_0000);
        chk(r, x);
    endtask
    task automatic irq(input logic [31:0] x);
        @(negedge sys_clk);
        chk({30'h0, txIrqReq, ctrlIrqReq}, x);
    endtask
    task automatic end_of_test;
        $display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        end_of_test();
    end
    initial begin
        {srst, clkEn} = 2'h3;
        {psel, penable, pwrite, txCtrlTaken, rxCtrlLoad, txFlush, rxFill} = 7'h00;
        {paddr, pwdata, rxCtrlIn} = 56'h0;
        k = $urandom(32'h0000_897e);
        repeat (6) @(posedge sys_clk);
        srst <= 1'h0;
        rd(SFF_OFF_STATUS, 32'h0);
        wr(SFF_OFF_PORT_CTRL, 32'h0000_0300);
        // register outputs settle after the completing edge
        @(negedge sys_clk);
        chk({30'h0, txEnable, rxEnable}, 32'h3);
        rd(SFF_OFF_STATUS, 32'h0000_3000);
        wr(SFF_OFF_IRQ_EN, 32'h0000_7600);
        irq(32'h3);
        // exact threshold, one past it, then a random level for each of the five legal codes
        for (int i = 0; i < 15; i++) begin
            code = (i < 3) ? 3'h0 : 3'(i / 3 + 3);
            thr = thrOf(code);
            k = (i % 3 < 2) ? 16 - thr + i % 3 : $urandom_range(16, 0);
            @(posedge sys_clk);
            txFlush <= 1'h1;
            @(posedge sys_clk);
            txFlush <= 1'h0;
            wr(SFF_OFF_FIFO_CTRL, {16'h0, code, 13'h0});
            repeat (k) wr(SFF_OFF_TX_DATA, $urandom);
            rd(SFF_OFF_FIFO_CTRL, {16'h0, code, 5'(16 - k), 8'h0});
            rd(SFF_OFF_STATUS, {18'h0, k == 0, 16 - k >= thr, 12'h0});
            irq({30'h0, 16 - k >= thr, k == 0});
        end
        wr(SFF_OFF_FIFO_CTRL, 32'h0000_4000);
        rd(SFF_OFF_FIFO_CTRL, {16'h0, 3'h7, 5'(16 - k), 8'h0});
        wr(SFF_OFF_IRQ_EN, 32'h0);
        irq(32'h0);
        wr(SFF_OFF_PORT_CTRL, 32'h0);
        wr(SFF_OFF_IRQ_EN, 32'h0000_4000);
        v = 16'($urandom);
        wr(SFF_OFF_TX_CTRL_DATA, {16'h0, v});
        @(negedge sys_clk);
        chk({16'h0, txCtrlData}, {16'h0, v});
        @(posedge sys_clk);
        txCtrlTaken <= 1'h1;
        @(posedge sys_clk);
        txCtrlTaken <= 1'h0;
        rd(SFF_OFF_STATUS, 32'h0000_4000);
        irq(32'h1);
        wr(SFF_OFF_TX_CTRL_DATA, {16'h0, ~v});
        rd(SFF_OFF_STATUS, 32'h0);
        @(posedge sys_clk);
        rxCtrlLoad <= 1'h1;
        rxCtrlIn <= v;
        @(posedge sys_clk);
        rxCtrlIn <= ~v;
        @(posedge sys_clk);
        rxCtrlLoad <= 1'h0;
        rd(SFF_OFF_STATUS, 32'h0);
        wr(SFF_OFF_PORT_CTRL, 32'h0000_0100);
        rd(SFF_OFF_STATUS, 32'h0000_0400);
        rd(SFF_OFF_RX_CTRL_DATA, {16'h0, ~v});
        rd(SFF_OFF_STATUS, 32'h0);
        @(posedge sys_clk);
        rxFill <= 1'h1;
        repeat (15) @(posedge sys_clk);
        rxFill <= 1'h0;
        rd(SFF_OFF_STATUS, 32'h0);
        @(posedge sys_clk);
        rxFill <= 1'h1;
        @(posedge sys_clk);
        rxFill <= 1'h0;
        rd(SFF_OFF_STATUS, 32'h0000_0200);
        rd(SFF_OFF_RX_DATA, 32'h5a00_0000);
        rd(SFF_OFF_STATUS, 32'h0);
        // a frozen block ignores control pulses
        @(posedge sys_clk);
        clkEn <= 1'h0;
        txCtrlTaken <= 1'h1;
        rxCtrlLoad <= 1'h1;
        @(posedge sys_clk);
        txCtrlTaken <= 1'h0;
        rxCtrlLoad <= 1'h0;
        @(posedge sys_clk);
        clkEn <= 1'h1;
        rd(SFF_OFF_STATUS, 32'h0);
        wr(SFF_OFF_STATUS, 32'h0);
        wr(8'h24, 32'h0);
        chk({31'h0, e}, 32'h1);
        @(posedge sys_clk);
        srst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'h0;
        rd(SFF_OFF_PORT_CTRL, 32'h0);
        rd(SFF_OFF_STATUS, 32'h0);
        end_of_test();
    end
endmodule
